// ==== logic/pfc_config.sv ====
// Phase, output range, shared-clock and switching-rate configuration.
// Assumes a command decoder delivering one-cycle write and read strobes
// with the command code, on i_ref_clk; run, supply and sync are pins.
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_config #(
    parameter int RELOCK_NS = `PFC_RELOCK_NS,
    parameter int CNT_W     = 16
) (
    // Clock and control
    input  wire logic             i_ref_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    // Command port
    input  wire logic             i_cmd_wr,
    input  wire logic             i_cmd_rd,
    input  wire logic [7:0]       i_cmd_code,
    input  wire logic [15:0]      i_cmd_data,
    output logic      [15:0]      o_rd_data,
    output logic                  o_rd_valid,
    output logic                  o_busy_fault,
    output logic                  o_cml_fault,
    // Run control
    input  wire logic [1:0]       i_run_pin,
    input  wire logic [1:0]       i_chan_cmd_on,
    input  wire logic             i_mask_pll_unlock,
    output logic                  o_running,
    // Input supply comparators
    input  wire logic             i_vin_above_on,
    input  wire logic             i_vin_below_off,
    // Synchronisation clock and phasing
    input  wire logic             i_sync_clk,
    output pfc_pkg::pfc_deg_t     o_ch0_phase_deg,
    output pfc_pkg::pfc_deg_t     o_ch1_phase_deg,
    output logic                  o_ch0_start,
    output logic                  o_ch1_start,
    // Output range
    output pfc_pkg::pfc_mv_t      o_ch0_vmax_mv,
    output pfc_pkg::pfc_mv_t      o_ch1_vmax_mv,
    // Switching rate and loop lock
    output logic                  o_ext_osc,
    output pfc_pkg::pfc_khz_t     o_freq_khz,
    output logic                  o_pll_unlock,
    output logic                  o_pll_unlock_fault,
    // Shared clock open-drain pin
    output logic                  o_share_clk_o,
    output logic                  o_share_clk_oe
);
    import pfc_pkg::*;

    localparam int RELOCK_CYC_RAW = (RELOCK_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS;
    localparam int RELOCK_CYC     = (RELOCK_CYC_RAW < 1) ? 1 : RELOCK_CYC_RAW;
    localparam int RL_W           = $clog2(RELOCK_CYC + 1);
    localparam int PROD_W         = CNT_W + 10;

    // Frequency decode: {valid, external, kHz}
    function automatic logic [11:0] freq_dec(input logic [15:0] code);
        unique case (code)
            `PFC_F_EXT:  freq_dec = {2'b11, `PFC_KHZ_NONE};
            `PFC_F_250:  freq_dec = {2'b10, `PFC_KHZ_250};
            `PFC_F_350:  freq_dec = {2'b10, `PFC_KHZ_350};
            `PFC_F_425:  freq_dec = {2'b10, `PFC_KHZ_425};
            `PFC_F_500:  freq_dec = {2'b10, `PFC_KHZ_500};
            `PFC_F_575:  freq_dec = {2'b10, `PFC_KHZ_575};
            `PFC_F_650:  freq_dec = {2'b10, `PFC_KHZ_650};
            `PFC_F_750:  freq_dec = {2'b10, `PFC_KHZ_750};
            `PFC_F_1000: freq_dec = {2'b10, `PFC_KHZ_1000};
            default:     freq_dec = {2'b00, `PFC_KHZ_NONE};
        endcase
    endfunction : freq_dec

    // Phase decode: {channel 1, channel 0} degrees
    function automatic logic [17:0] phase_dec(input logic [2:0] code);
        unique case (code)
            `PFC_PH_0_180:   phase_dec = {`PFC_DEG_180, `PFC_DEG_0};
            `PFC_PH_90_270:  phase_dec = {`PFC_DEG_270, `PFC_DEG_90};
            `PFC_PH_0_240:   phase_dec = {`PFC_DEG_240, `PFC_DEG_0};
            `PFC_PH_0_120:   phase_dec = {`PFC_DEG_120, `PFC_DEG_0};
            `PFC_PH_120_240: phase_dec = {`PFC_DEG_240, `PFC_DEG_120};
            `PFC_PH_60_240:  phase_dec = {`PFC_DEG_240, `PFC_DEG_60};
            `PFC_PH_120_300: phase_dec = {`PFC_DEG_300, `PFC_DEG_120};
            default:         phase_dec = {`PFC_DEG_180, `PFC_DEG_0};
        endcase
    endfunction : phase_dec

    // Pin synchronisers: run[1:0], above-on, below-off, sync
    wire  [4:0] pin_lvl;
    wire  [4:0] pin_fall;

    pfc_edge_sync #(.W(5)) u_pins (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_async   ({i_sync_clk, i_vin_below_off, i_vin_above_on,
                     i_run_pin}),
        .o_level   (pin_lvl),
        .o_rise    (),
        .o_fall    (pin_fall)
    );

    wire        input_turn_on_threshold_s   = pin_lvl[2];
    wire        input_turn_off_threshold_s  = pin_lvl[3];
    wire        sync_fall  = pin_fall[4];

    // State
    logic [7:0]        phase_cfg_ff;
    logic [15:0]       freq_cfg_ff;
    logic [2:0]        act_phase_ff;
    logic [15:0]       act_freq_ff;
    logic              running_ff;
    logic [15:0]       rd_data_ff;
    logic              rd_valid_ff;
    logic              busy_ff;
    logic              cml_ff;
    pfc_mv_t           vmax0_ff;
    pfc_mv_t           vmax1_ff;
    logic              vin_ok_ff;
    logic              powered_ff;
    pfc_pll_st_t       pll_st_ff;
    logic [RL_W-1:0]   relock_cnt_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  period_ff;
    logic [1:0]        fired_ff;

    // Off while the run pins are low or the channels are commanded off
    wire        running    = |(pin_lvl[1:0] & i_chan_cmd_on);
    wire        start_edge = running & ~running_ff;

    wire        wr_phase   = i_ce & i_cmd_wr &
                             (i_cmd_code == `PFC_CMD_PHASE);
    wire        wr_freq    = i_ce & i_cmd_wr &
                             (i_cmd_code == `PFC_CMD_FREQ);
    wire        wr_cfg     = wr_phase | wr_freq;
    wire [2:0]  new_ph     = i_cmd_data[`PFC_PH_MSB:`PFC_PH_LSB];
    wire [11:0] new_fdec   = freq_dec(i_cmd_data);
    wire        ph_bad     = (new_ph == `PFC_PH_BAD);
    wire        fr_bad     = ~new_fdec[11];
    wire        bad_val    = (wr_phase & ph_bad) | (wr_freq & fr_bad);
    wire        take_phase = wr_phase & ~running & ~ph_bad;
    wire        take_freq  = wr_freq & ~running & ~fr_bad;
    wire        freq_chg   = start_edge & (freq_cfg_ff != act_freq_ff);

    // Bit 7 is held at zero, bit 3 keeps what was written
    wire [7:0]  phase_wdat = {1'b0, i_cmd_data[6:0]};

    wire [11:0] act_fdec   = freq_dec(act_freq_ff);
    wire [17:0] act_deg    = phase_dec(act_phase_ff);

    wire [15:0] rd_mux     =
        (i_cmd_code == `PFC_CMD_PHASE) ? {8'h00, phase_cfg_ff} :
        (i_cmd_code == `PFC_CMD_FREQ)  ? freq_cfg_ff : 16'h0000;

    wire        share_en   = phase_cfg_ff[`PFC_BIT_SHARE];
    wire        rng0       = phase_cfg_ff[`PFC_BIT_RANGE0];
    wire        rng1       = phase_cfg_ff[`PFC_BIT_RANGE1];
    wire pfc_mv_t nxt_vmax0 = rng0 ? `PFC_MV_LOW : `PFC_MV_CH0_HIGH;
    wire pfc_mv_t nxt_vmax1 = rng1 ? `PFC_MV_LOW : `PFC_MV_CH1_HIGH;

    // Hysteresis on the supply comparators
    wire nxt_vin_ok = input_turn_on_threshold_s ? 1'b1 : (input_turn_off_threshold_s ? 1'b0 : vin_ok_ff);

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            phase_cfg_ff <= `PFC_PHASE_RST;
            freq_cfg_ff  <= `PFC_FREQ_RST;
        end else if (take_phase) begin
            phase_cfg_ff <= phase_wdat;
        end else if (take_freq) begin
            freq_cfg_ff  <= i_cmd_data;
        end
    end

    // New phase and rate settings reach the converter only at the next start
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            act_phase_ff <= 3'(`PFC_PHASE_RST);
            act_freq_ff  <= `PFC_FREQ_RST;
        end else if (i_ce && start_edge) begin
            act_phase_ff <= phase_cfg_ff[`PFC_PH_MSB:`PFC_PH_LSB];
            act_freq_ff  <= freq_cfg_ff;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            running_ff  <= 1'b0;
            rd_data_ff  <= 16'h0000;
            rd_valid_ff <= 1'b0;
            busy_ff     <= 1'b0;
            cml_ff      <= 1'b0;
            vmax0_ff    <= `PFC_MV_CH0_HIGH;
            vmax1_ff    <= `PFC_MV_CH1_HIGH;
        end else if (i_ce) begin
            running_ff  <= running;
            rd_data_ff  <= i_cmd_rd ? rd_mux : rd_data_ff;
            rd_valid_ff <= i_cmd_rd;
            busy_ff     <= wr_cfg & running;
            cml_ff      <= bad_val & ~running;
            vmax0_ff    <= nxt_vmax0;
            vmax1_ff    <= nxt_vmax1;
        end
    end

    // Shared clock release: powered_ff marks the first supply ramp done
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            vin_ok_ff  <= 1'b0;
            powered_ff <= 1'b0;
        end else if (i_ce) begin
            vin_ok_ff  <= nxt_vin_ok;
            powered_ff <= powered_ff | nxt_vin_ok;
        end
    end

    // Lock loss stands for a fixed relock window after a rate change
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pll_st_ff     <= PFC_PLL_LOCKED;
            relock_cnt_ff <= '0;
        end else if (i_ce) begin
            unique case (pll_st_ff)
                PFC_PLL_LOCKED: begin
                    if (freq_chg) begin
                        pll_st_ff     <= PFC_PLL_RELOCK;
                        relock_cnt_ff <= RL_W'(RELOCK_CYC - 1);
                    end
                end
                PFC_PLL_RELOCK: begin
                    if (relock_cnt_ff == '0) begin
                        pll_st_ff <= PFC_PLL_LOCKED;
                    end else begin
                        relock_cnt_ff <= relock_cnt_ff - 1'b1;
                    end
                end
                default: begin
                    pll_st_ff <= PFC_PLL_LOCKED;
                end
            endcase
        end
    end

    // Sync period measured in reference cycles between falling edges
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cnt_ff    <= '0;
            period_ff <= '0;
        end else if (i_ce) begin
            if (sync_fall) begin
                cnt_ff    <= '0;
                period_ff <= cnt_ff + 1'b1;
            end else if (cnt_ff != '1) begin
                cnt_ff    <= cnt_ff + 1'b1;
            end
        end
    end

    // Each channel fires once per period when cnt*360 reaches period*deg;
    // multiplying avoids a divider at the cost of two wide comparators
    wire [1:0] hit;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            wire [PROD_W-1:0] lhs = PROD_W'(cnt_ff) * PROD_W'(`PFC_DEG_FULL);
            wire [PROD_W-1:0] rhs = PROD_W'(period_ff) *
                                    PROD_W'(act_deg[ch*9 +: 9]);
            assign hit[ch] = running_ff & (period_ff != '0) &
                             (lhs >= rhs) & ~fired_ff[ch];
        end
    endgenerate

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            fired_ff <= 2'b11;
        end else if (i_ce) begin
            fired_ff <= sync_fall ? 2'b00 : (fired_ff | hit);
        end
    end

    // Outputs
    assign o_rd_data          = rd_data_ff;
    assign o_rd_valid         = rd_valid_ff;
    assign o_busy_fault       = busy_ff;
    assign o_cml_fault        = cml_ff;
    assign o_running          = running_ff;
    assign o_ch0_phase_deg    = act_deg[8:0];
    assign o_ch1_phase_deg    = act_deg[17:9];
    assign o_ch0_start        = hit[0];
    assign o_ch1_start        = hit[1];
    assign o_ch0_vmax_mv      = vmax0_ff;
    assign o_ch1_vmax_mv      = vmax1_ff;
    assign o_ext_osc          = act_fdec[10];
    assign o_freq_khz         = act_fdec[9:0];
    assign o_pll_unlock       = (pll_st_ff == PFC_PLL_RELOCK);
    assign o_pll_unlock_fault = o_pll_unlock & ~i_mask_pll_unlock;
    assign o_share_clk_o      = 1'b0;
    assign o_share_clk_oe     = share_en ? ~vin_ok_ff
                                         : ~powered_ff;

endmodule : pfc_config

// ==== logic/pfc_defs.svh ====
// Constants of the phase and switching-rate configuration block.
// Assumes inclusion by bare name from the logic/ files.
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// Command codes that select the two settings
`define PFC_CMD_PHASE    8'hf5
`define PFC_CMD_FREQ     8'h33

// Power-on values of the two settings
`define PFC_PHASE_RST    8'h10
`define PFC_FREQ_RST     16'hfabc

// Field positions in the phase/range byte
`define PFC_BIT_RSVD7    7
`define PFC_BIT_RANGE0   6
`define PFC_BIT_RANGE1   5
`define PFC_BIT_SHARE    4
`define PFC_PH_MSB       2
`define PFC_PH_LSB       0
`define PFC_PH_BAD       3'h7

// Phase codes
`define PFC_PH_0_180     3'h0
`define PFC_PH_90_270    3'h1
`define PFC_PH_0_240     3'h2
`define PFC_PH_0_120     3'h3
`define PFC_PH_120_240   3'h4
`define PFC_PH_60_240    3'h5
`define PFC_PH_120_300   3'h6

// Offsets in degrees
`define PFC_DEG_0        9'h000
`define PFC_DEG_60       9'h03c
`define PFC_DEG_90       9'h05a
`define PFC_DEG_120      9'h078
`define PFC_DEG_180      9'h0b4
`define PFC_DEG_240      9'h0f0
`define PFC_DEG_270      9'h10e
`define PFC_DEG_300      9'h12c
`define PFC_DEG_FULL     9'h168

// Linear-format frequency codes
`define PFC_F_EXT        16'h0000
`define PFC_F_250        16'hf3e8
`define PFC_F_350        16'hfabc
`define PFC_F_425        16'hfb52
`define PFC_F_500        16'hfbe8
`define PFC_F_575        16'h023f
`define PFC_F_650        16'h028a
`define PFC_F_750        16'h02ee
`define PFC_F_1000       16'h03e8

// Resulting frequencies in kHz
`define PFC_KHZ_NONE     10'h000
`define PFC_KHZ_250      10'h0fa
`define PFC_KHZ_350      10'h15e
`define PFC_KHZ_425      10'h1a9
`define PFC_KHZ_500      10'h1f4
`define PFC_KHZ_575      10'h23f
`define PFC_KHZ_650      10'h28a
`define PFC_KHZ_750      10'h2ee
`define PFC_KHZ_1000     10'h3e8

// Output ceilings in millivolts
`define PFC_MV_LOW       13'h0abe
`define PFC_MV_CH0_HIGH  13'h1000
`define PFC_MV_CH1_HIGH  13'h157c

// Timing
`define PFC_CLK_NS       25
`define PFC_RELOCK_NS    10000

`endif

// ==== logic/pfc_pkg.sv ====
// Types of the phase and switching-rate configuration block.
// Uses no constants of pfc_defs.svh; its widths and state encodings are literal.
package pfc_pkg;

    typedef logic [8:0]  pfc_deg_t;
    typedef logic [9:0]  pfc_khz_t;
    typedef logic [12:0] pfc_mv_t;

    typedef enum logic [1:0] {
        PFC_PLL_LOCKED = 2'b01,
        PFC_PLL_RELOCK = 2'b10
    } pfc_pll_st_t;

endpackage : pfc_pkg

// ==== logic/pfc_edge_sync.sv ====
// Two-stage synchroniser with edge detection for a group of pin levels.
// Assumes the inputs are asynchronous to i_ref_clk.
`timescale 1ns/1ps
module pfc_edge_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         i_ref_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_ce,
    // Pins
    input  wire logic [W-1:0] i_async,
    // Synchronised view
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    import pfc_pkg::*;

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // Only sync_ff reads meta_ff, so no logic sees a metastable level
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else if (i_ce) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign o_level = sync_ff;
    assign o_rise  = sync_ff & ~prev_ff;
    assign o_fall  = prev_ff & ~sync_ff;

endmodule : pfc_edge_sync

// ==== verification/pfc_config_sva.sv ====
// Checker for pfc_config: command answers, faults, apply and pins.
// Assumes it is bound to pfc_config and sees only its ports.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_config_sva #(
    parameter int RELOCK_NS = `PFC_RELOCK_NS,
    parameter int CNT_W     = 16
) (
    // Clock, reset and command port
    input wire logic              i_ref_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_ce,
    input wire logic              i_cmd_wr,
    input wire logic              i_cmd_rd,
    input wire logic [7:0]        i_cmd_code,
    input wire logic [15:0]       i_cmd_data,
    input wire logic              i_mask_pll_unlock,
    input wire logic              o_rd_valid,
    input wire logic              o_busy_fault,
    input wire logic              o_cml_fault,
    // Applied state
    input wire logic              o_running,
    input wire logic              o_ch0_start,
    input wire logic              o_ch1_start,
    input wire pfc_pkg::pfc_deg_t o_ch0_phase_deg,
    input wire pfc_pkg::pfc_deg_t o_ch1_phase_deg,
    input wire pfc_pkg::pfc_mv_t  o_ch0_vmax_mv,
    input wire pfc_pkg::pfc_mv_t  o_ch1_vmax_mv,
    input wire logic              o_ext_osc,
    input wire pfc_pkg::pfc_khz_t o_freq_khz,
    input wire logic              o_pll_unlock,
    input wire logic              o_pll_unlock_fault,
    input wire logic              o_share_clk_o,
    input wire logic              o_share_clk_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_cfg_wr;
        i_ce && i_cmd_wr && (i_cmd_code == `PFC_CMD_PHASE
                             || i_cmd_code == `PFC_CMD_FREQ);
    endsequence
    sequence s_ph_ok;
        i_ce && i_cmd_wr && i_cmd_code == `PFC_CMD_PHASE && !o_running
            && i_cmd_data[2:0] != `PFC_PH_BAD;
    endsequence

    property p_busy;
        s_cfg_wr ##0 o_running |=> o_busy_fault && !o_cml_fault;
    endproperty
    a_busy: assert property (p_busy) else $error("busy pulse missing");
    property p_cml_ph;
        s_cfg_wr ##0 (!o_running && i_cmd_code == `PFC_CMD_PHASE
            && i_cmd_data[2:0] == `PFC_PH_BAD) |=> o_cml_fault && !o_busy_fault;
    endproperty
    a_cml_ph: assert property (p_cml_ph) else $error("bad phase kept");
    property p_rng0;
        s_ph_ok |-> ##2 o_ch0_vmax_mv == ($past(i_cmd_data[6], 2)
            ? `PFC_MV_LOW : `PFC_MV_CH0_HIGH);
    endproperty
    a_rng0: assert property (p_rng0) else $error("ch0 ceiling wrong");
    property p_rng1;
        s_ph_ok |-> ##2 o_ch1_vmax_mv == ($past(i_cmd_data[5], 2)
            ? `PFC_MV_LOW : `PFC_MV_CH1_HIGH);
    endproperty
    a_rng1: assert property (p_rng1) else $error("ch1 ceiling wrong");
    property p_rd;
        i_ce && i_cmd_rd |=> o_rd_valid;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_hold;
        !$rose(o_running) |-> $stable(o_freq_khz) && $stable(o_ch0_phase_deg)
            && $stable(o_ch1_phase_deg);
    endproperty
    a_hold: assert property (p_hold) else $error("applied early");
    property p_relock;
        $rose(o_pll_unlock) |-> $rose(o_running);
    endproperty
    a_relock: assert property (p_relock) else $error("stray unlock");
    property p_mask;
        o_pll_unlock_fault == (o_pll_unlock && !i_mask_pll_unlock);
    endproperty
    a_mask: assert property (p_mask) else $error("unlock mask wrong");
    property p_start;
        o_ch0_start || o_ch1_start |-> o_running;
    endproperty
    a_start: assert property (p_start) else $error("start while off");
    property p_ext;
        o_ext_osc |-> o_freq_khz == `PFC_KHZ_NONE;
    endproperty
    a_ext: assert property (p_ext) else $error("ext osc with rate");
    property p_od;
        o_share_clk_oe |-> !o_share_clk_o;
    endproperty
    a_od: assert property (p_od) else $error("shared clock driven high");
endmodule : pfc_config_sva

bind pfc_config pfc_config_sva #(.RELOCK_NS(RELOCK_NS), .CNT_W(CNT_W)) sva_i (
    .i_ref_clk, .i_sys_rst, .i_ce, .i_cmd_wr, .i_cmd_rd, .i_cmd_code,
    .i_cmd_data, .i_mask_pll_unlock, .o_rd_valid, .o_busy_fault,
    .o_cml_fault, .o_running, .o_ch0_start, .o_ch1_start, .o_ch0_phase_deg,
    .o_ch1_phase_deg, .o_ch0_vmax_mv, .o_ch1_vmax_mv, .o_ext_osc,
    .o_freq_khz, .o_pll_unlock, .o_pll_unlock_fault, .o_share_clk_o,
    .o_share_clk_oe);

// ==== verification/pfc_host_model.sv ====
// Bus host model: one-cycle write and read strobes on the command port.
// Assumes the bench calls issue() and that inputs move at falling edges.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_host_model (
    // Clock
    input  wire logic i_ref_clk,
    // Command port
    output logic        o_cmd_wr,
    output logic        o_cmd_rd,
    output logic [7:0]  o_cmd_code,
    output logic [15:0] o_cmd_data
);
    initial begin
        o_cmd_wr   = 1'b0;
        o_cmd_rd   = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_data = 16'h0000;
    end
    // Idle data is inverted so a stale word can never pass as fresh
    task automatic issue(input logic wr, input logic [7:0] code,
                         input logic [15:0] data);
        logic [15:0] d;
        d = (code == `PFC_CMD_PHASE) ? {8'h00, 1'b0, data[6:0]} : data;
        @(negedge i_ref_clk);
        o_cmd_wr   = wr;
        o_cmd_rd   = ~wr;
        o_cmd_code = code;
        o_cmd_data = d;
        @(negedge i_ref_clk);
        o_cmd_wr   = 1'b0;
        o_cmd_rd   = 1'b0;
        o_cmd_data = ~d;
    endtask : issue
endmodule : pfc_host_model

// ==== verification/pfc_config_tb_top.sv ====
// Self-checking bench for pfc_config with a bus host model.
// Assumes a 40 MHz clock and a free 200 ns sync clock.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_config_tb_top;
    import pfc_pkg::*;
    localparam int RELOCK_CYC = 100;
    logic i_ref_clk = 0, i_sys_rst = 1, i_ce = 1, i_mask_pll_unlock = 0;
    logic [1:0] i_run_pin = 0, i_chan_cmd_on = 2'b11;
    logic i_vin_above_on = 0, i_vin_below_off = 0, i_sync_clk = 0;
    logic i_cmd_wr, i_cmd_rd, o_rd_valid, o_busy_fault, o_cml_fault;
    logic o_running, o_ch0_start, o_ch1_start, o_ext_osc, o_pll_unlock;
    logic o_pll_unlock_fault, o_share_clk_o, o_share_clk_oe;
    logic [7:0] i_cmd_code;
    logic [15:0] i_cmd_data, o_rd_data, d, prev;
    pfc_deg_t o_ch0_phase_deg, o_ch1_phase_deg;
    pfc_mv_t o_ch0_vmax_mv, o_ch1_vmax_mv;
    pfc_khz_t o_freq_khz;
    logic [17:0] exp_q[$];
    int num_errors = 0, checked = 0, cycles = 0, seed = 79354, b, n;
    int deg0[7] = '{0, 90, 0, 0, 120, 60, 120};
    int deg1[7] = '{180, 270, 240, 120, 240, 240, 300};
    logic [15:0] fc[10] = '{16'h0000, 16'hf3e8, 16'hfabc, 16'hfb52,
        16'hfbe8, 16'h023f, 16'h028a, 16'h02ee, 16'h03e8, 16'h03e8};
    int fk[10] = '{0, 250, 350, 425, 500, 575, 650, 750, 1000, 1000};

    always #12.5 i_ref_clk = ~i_ref_clk;
    always #100 i_sync_clk = ~i_sync_clk;

    pfc_host_model pfc_host_model_i (.i_ref_clk(i_ref_clk),
        .o_cmd_wr(i_cmd_wr), .o_cmd_rd(i_cmd_rd), .o_cmd_code(i_cmd_code),
        .o_cmd_data(i_cmd_data));
    pfc_config #(.RELOCK_NS(RELOCK_CYC * 25)) pfc_config_i (
        .i_ref_clk, .i_sys_rst, .i_ce, .i_cmd_wr, .i_cmd_rd, .i_cmd_code,
        .i_cmd_data, .o_rd_data, .o_rd_valid, .o_busy_fault, .o_cml_fault,
        .i_run_pin, .i_chan_cmd_on, .i_mask_pll_unlock, .o_running,
        .i_vin_above_on, .i_vin_below_off, .i_sync_clk, .o_ch0_phase_deg,
        .o_ch1_phase_deg, .o_ch0_start, .o_ch1_start, .o_ch0_vmax_mv,
        .o_ch1_vmax_mv, .o_ext_osc, .o_freq_khz, .o_pll_unlock,
        .o_pll_unlock_fault, .o_share_clk_o, .o_share_clk_oe);

    task automatic check_val(string name, logic [17:0] e, logic [17:0] g);
        checked++;
        if (e !== g) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : check_val
    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Kind 1 read, 2 busy, 3 unsupported value
    task automatic wr(logic [7:0] c, logic [15:0] v, logic [1:0] k);
        if (k != 0) exp_q.push_back({k, 16'h0});
        pfc_host_model_i.issue(1'b1, c, v);
    endtask : wr
    task automatic rd(logic [7:0] c, logic [15:0] v);
        exp_q.push_back({2'd1, v});
        pfc_host_model_i.issue(1'b0, c, 16'h0);
    endtask : rd
    task automatic run(logic on, int w);
        i_run_pin = {2{on}};
        repeat (w) @(negedge i_ref_clk);
    endtask : run
    task automatic vin(logic up);
        i_vin_above_on = up;
        i_vin_below_off = ~up;
        repeat (2) @(negedge i_ref_clk);
        i_vin_above_on = 0;
        i_vin_below_off = 0;
        repeat (6) @(negedge i_ref_clk);
    endtask : vin

    always @(negedge i_ref_clk) begin
        if (!i_sys_rst && (o_rd_valid | o_busy_fault | o_cml_fault) === 1'b1)
            check_val("result", exp_q.size() ? exp_q.pop_front() : 18'h0,
                o_rd_valid ? {2'd1, o_rd_data}
                : {o_busy_fault ? 2'd2 : 2'd3, 16'h0});
    end
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(negedge i_ref_clk);
        i_sys_rst = 0;
        rd(`PFC_CMD_PHASE, 16'h0010);
        rd(`PFC_CMD_FREQ, 16'hfabc);
        check_val("oe", 1, o_share_clk_oe);
        vin(1);
        check_val("oe", 0, o_share_clk_oe);
        vin(0);
        check_val("oe", 1, o_share_clk_oe);
        vin(1);
        wr(`PFC_CMD_PHASE, 16'h0000, 0);
        vin(0);
        check_val("oe", 0, o_share_clk_oe);
        for (int c = 0; c < 7; c++) begin
            b = $random(seed);
            d = {9'h0, b[6:3], c[2:0]};
            wr(`PFC_CMD_PHASE, d, 0);
            rd(`PFC_CMD_PHASE, d);
            check_val("vmax0", d[6] ? `PFC_MV_LOW : `PFC_MV_CH0_HIGH, o_ch0_vmax_mv);
            check_val("vmax1", d[5] ? `PFC_MV_LOW : `PFC_MV_CH1_HIGH, o_ch1_vmax_mv);
            run(1, 6);
            check_val("run", 1, o_running);
            check_val("deg0", deg0[c], o_ch0_phase_deg);
            check_val("deg1", deg1[c], o_ch1_phase_deg);
            n = 0;
            while (o_ch0_start !== 1'b1 && n < 40) begin
                @(negedge i_ref_clk);
                n++;
            end
            n = 0;
            do begin
                @(negedge i_ref_clk);
                n++;
            end while (o_ch1_start !== 1'b1 && n < 9);
            check_val("gap", (8 * deg1[c] + 359) / 360 - (8 * deg0[c] + 359) / 360, n);
            run(0, 4);
        end
        run(1, 6);
        wr(`PFC_CMD_PHASE, 16'h0003, 2);
        wr(`PFC_CMD_FREQ, 16'h03e8, 2);
        rd(`PFC_CMD_PHASE, d);
        i_chan_cmd_on = 2'b00;
        run(1, 6);
        check_val("run", 0, o_running);
        wr(`PFC_CMD_PHASE, 16'h0010, 0);
        rd(`PFC_CMD_PHASE, 16'h0010);
        wr(`PFC_CMD_PHASE, 16'h0017, 3);
        wr(`PFC_CMD_FREQ, 16'h1234, 3);
        // Let the fault pulse clear, then a write with the enable low is lost
        @(negedge i_ref_clk);
        i_ce = 0;
        wr(`PFC_CMD_PHASE, 16'h0003, 0);
        i_ce = 1;
        rd(`PFC_CMD_PHASE, 16'h0010);
        rd(`PFC_CMD_FREQ, 16'hfabc);
        run(0, 4);
        i_chan_cmd_on = 2'b11;
        prev = 16'hfabc;
        for (int i = 0; i < 10; i++) begin
            wr(`PFC_CMD_FREQ, fc[i], 0);
            rd(`PFC_CMD_FREQ, fc[i]);
            i_mask_pll_unlock = i[0];
            check_val("hold", fk[i == 0 ? 2 : i - 1], o_freq_khz);
            run(1, 6);
            check_val("khz", fk[i], o_freq_khz);
            check_val("ext", fc[i] == 0, o_ext_osc);
            check_val("unlk", fc[i] != prev, o_pll_unlock);
            check_val("flt", fc[i] != prev && !i[0], o_pll_unlock_fault);
            run(1, RELOCK_CYC + 5);
            check_val("relock", 0, o_pll_unlock);
            run(0, 4);
            prev = fc[i];
        end
        repeat (4) @(negedge i_ref_clk);
        check_val("pending", 0, exp_q.size());
        tally_and_finish();
    end
endmodule : pfc_config_tb_top
